// [rtl/asw_top.sv]
// How it works
// - with the enable switch off the supervisor idles; switching it on starts both timers.
// - a gap between reset pulses longer than the short period raises the program error flag.
// - the pulse-seen output follows the arrival of programmed reset pulses.
// - armed is high only when enabled, cassette in, pulses arriving and tape at load point.
// - the load-active output is high while the program loads; it drops at load done, before pulses return.
// - a reload with no pulses is retried until the limit runs out, then retry limit is set.
// - a power interruption latches the power flag so it is seen after power returns.
// - the three history flags hold until the enable switch goes off and back on; a host or panel clear drops them, the power flag only with the switch on.
// - while enabled and reloading, manual rewind and manual load requests are ignored.
// - the node is master-cleared by power-on reset, the host clear or the panel clear.
//
// Decided for this implementation: the APB slave port and the register offsets.
`timescale 1ns/100ps
module asw_top #(
   parameter int TICK_CYCLES = asw_pkg::TICK_CYCLES,
   parameter int HB_TICKS = asw_pkg::HB_TICKS,
   parameter int SUP_TICKS = asw_pkg::SUP_TICKS,
   parameter int RETRY_LIMIT = asw_pkg::RETRY_DEF
) (
   input wire logic I_MCLK,
   input wire logic I_NRST,
   input wire logic I_HOST_MCLR,
   input wire logic I_PANEL_MCLR,
   input wire logic I_ENABLE_SW,
   input wire logic I_RESET_PULSE,
   input wire logic I_CASSETTE_IN,
   input wire logic I_LOAD_POINT,
   input wire logic I_DRIVE_READY,
   input wire logic I_LOAD_DONE,
   input wire logic I_POWER_FAIL,
   input wire logic I_MAN_REWIND,
   input wire logic I_MANUAL_LOAD_REQUEST,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [asw_pkg::ADDR_W-1:0] I_PADDR,
   input wire logic [asw_pkg::DATA_W-1:0] I_PWDATA,
   output logic [asw_pkg::DATA_W-1:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   output logic O_PULSE_SEEN,
   output logic O_ARMED,
   output logic O_LOAD_ACTIVE,
   output logic O_RETRY_LIMIT,
   output logic O_PROG_ERROR,
   output logic O_POWER_INT,
   output logic O_REWIND,
   output logic O_START_LOAD,
   output logic O_IRQ
);
   localparam int TW = $clog2(TICK_CYCLES + 1);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
   localparam int CW = asw_pkg::CNT_W;
   localparam logic [CW-1:0] RETRY_RST = CW'(RETRY_LIMIT);

   asw_pkg::asw_state_t state, next_state;
   logic [TW-1:0] tick_cnt, next_tick_cnt;
   logic tick, next_tick;
   logic en_q, pulse_q;
   logic [CW-1:0] retry_cnt, next_retry_cnt;
   logic [CW-1:0] retry_cfg, next_retry_cfg;
   logic load_pending, next_load_pending;
   logic next_pulse_seen, next_armed, next_load_active, next_retry_flag;
   logic next_prog_error, next_power_int, next_rewind, next_start_load;
   logic [asw_pkg::IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
   logic [asw_pkg::IRQ_W-1:0] events;
   logic next_irq, next_pready, next_pslverr;
   logic [asw_pkg::DATA_W-1:0] next_prdata;
   logic mclr, sw_en, en_rise, beat, hb_exp, sup_exp, hb_restart, sup_restart;
   logic inhibit, attempt_fail, last_try, hb_err_evt, exh_evt, wr_en;

   assign mclr = I_HOST_MCLR | I_PANEL_MCLR;
   assign sw_en = I_ENABLE_SW;
   assign en_rise = I_ENABLE_SW & ~en_q;
   assign beat = I_RESET_PULSE & ~pulse_q;
   assign wr_en = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;

   default clocking cb @(posedge I_MCLK);
   endclocking
   default disable iff (!I_NRST || mclr);

   // millisecond tick divider
   always_comb begin
      next_tick_cnt = tick_cnt + TW'(1);
      next_tick = 1'b0;
      if (tick_cnt == TICK_LAST) begin
         next_tick_cnt = '0;
         next_tick = 1'b1;
      end
   end

   always_ff @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         tick_cnt <= '0;
         tick <= 1'b0;
         en_q <= 1'b0;
         pulse_q <= 1'b0;
      end else begin
         tick_cnt <= next_tick_cnt;
         tick <= next_tick;
         en_q <= mclr ? 1'b0 : I_ENABLE_SW;
         pulse_q <= I_RESET_PULSE;
      end
   end

   assign hb_restart = mclr | en_rise | beat | (state != asw_pkg::ST_WATCH);
   assign sup_restart = mclr | en_rise | (beat && state == asw_pkg::ST_WATCH)
      | (next_state == asw_pkg::ST_LOAD && state != asw_pkg::ST_LOAD);

   asw_timer #(.LIMIT(HB_TICKS)) u_hb_timer (
      .i_clk(I_MCLK),
      .i_nrst(I_NRST),
      .i_tick(tick),
      .i_restart(hb_restart),
      .o_expired(hb_exp)
   );

   asw_timer #(.LIMIT(SUP_TICKS)) u_sup_timer (
      .i_clk(I_MCLK),
      .i_nrst(I_NRST),
      .i_tick(tick),
      .i_restart(sup_restart),
      .o_expired(sup_exp)
   );

   assign last_try = ({1'b0, retry_cnt} + 9'h001) >= {1'b0, retry_cfg};
   assign attempt_fail = sup_exp && !beat
      && (state == asw_pkg::ST_LOAD || state == asw_pkg::ST_VERIFY);
   assign hb_err_evt = sw_en && state == asw_pkg::ST_WATCH && hb_exp && !beat;
   assign exh_evt = sw_en && attempt_fail && last_try;
   assign inhibit = sw_en && (state == asw_pkg::ST_LOAD || state == asw_pkg::ST_VERIFY);

   // supervisor sequence
   always_comb begin
      next_state = state;
      next_retry_cnt = retry_cnt;
      next_load_pending = load_pending;
      next_start_load = I_MANUAL_LOAD_REQUEST && !inhibit;
      unique case (state)
         asw_pkg::ST_OFF: begin
            if (en_rise) begin
               next_state = asw_pkg::ST_WATCH;
            end
         end
         asw_pkg::ST_WATCH: begin
            if (hb_err_evt) begin
               next_state = asw_pkg::ST_LOAD;
               next_retry_cnt = '0;
               next_load_pending = 1'b1;
            end
         end
         asw_pkg::ST_LOAD: begin
            if (!I_DRIVE_READY) begin
               next_load_pending = 1'b1;
            end else if (load_pending) begin
               next_start_load = 1'b1;
               next_load_pending = 1'b0;
            end else if (I_LOAD_DONE) begin
               next_state = asw_pkg::ST_VERIFY;
            end
         end
         asw_pkg::ST_VERIFY: begin
            if (beat) begin
               next_state = asw_pkg::ST_WATCH;
            end
         end
         asw_pkg::ST_EXHAUST: begin
            next_state = asw_pkg::ST_EXHAUST;
         end
      endcase
      if (attempt_fail) begin
         if (last_try) begin
            next_state = asw_pkg::ST_EXHAUST;
         end else begin
            next_state = asw_pkg::ST_LOAD;
            next_retry_cnt = retry_cnt + CW'(1);
            next_load_pending = 1'b1;
         end
      end
      if (!sw_en || mclr) begin
         next_state = asw_pkg::ST_OFF;
         next_load_pending = 1'b0;
      end
   end

   always_ff @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         state <= asw_pkg::ST_OFF;
         retry_cnt <= '0;
         load_pending <= 1'b0;
         O_START_LOAD <= 1'b0;
      end else begin
         state <= next_state;
         retry_cnt <= next_retry_cnt;
         load_pending <= next_load_pending;
         O_START_LOAD <= next_start_load;
      end
   end

   // indicators and history flags
   always_comb begin
      next_pulse_seen = sw_en && !mclr
         && (beat || (O_PULSE_SEEN && !hb_exp && state == asw_pkg::ST_WATCH));
      next_armed = sw_en && I_CASSETTE_IN && next_pulse_seen && I_LOAD_POINT;
      next_load_active = (next_state == asw_pkg::ST_LOAD);
      next_prog_error = O_PROG_ERROR && !en_rise;
      next_retry_flag = O_RETRY_LIMIT && !en_rise;
      next_power_int = O_POWER_INT && !en_rise;
      if (hb_err_evt) begin
         next_prog_error = 1'b1;
      end
      if (exh_evt) begin
         next_retry_flag = 1'b1;
      end
      if (I_POWER_FAIL) begin
         next_power_int = 1'b1;
      end
      if (mclr) begin
         next_prog_error = 1'b0;
         next_retry_flag = 1'b0;
      end
      next_rewind = I_MAN_REWIND && !inhibit;
   end

   always_ff @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_PULSE_SEEN <= 1'b0;
         O_ARMED <= 1'b0;
         O_LOAD_ACTIVE <= 1'b0;
         O_PROG_ERROR <= 1'b0;
         O_RETRY_LIMIT <= 1'b0;
         O_POWER_INT <= 1'b0;
         O_REWIND <= 1'b0;
      end else begin
         O_PULSE_SEEN <= next_pulse_seen;
         O_ARMED <= next_armed;
         O_LOAD_ACTIVE <= next_load_active;
         O_PROG_ERROR <= next_prog_error;
         O_RETRY_LIMIT <= next_retry_flag;
         O_POWER_INT <= next_power_int;
         O_REWIND <= next_rewind;
      end
   end

   // apb registers and interrupt
   always_comb begin
      events = '0;
      events[asw_pkg::EV_HB_BIT] = hb_err_evt;
      events[asw_pkg::EV_EXH_BIT] = exh_evt;
      events[asw_pkg::EV_PWR_BIT] = I_POWER_FAIL;
      events[asw_pkg::EV_LOAD_BIT] = next_start_load && inhibit;
      next_irq_stat = irq_stat;
      next_irq_mask = irq_mask;
      next_retry_cfg = retry_cfg;
      if (wr_en) begin
         unique case (I_PADDR)
            asw_pkg::REG_IRQ_STAT: next_irq_stat = irq_stat & ~I_PWDATA[asw_pkg::IRQ_W-1:0];
            asw_pkg::REG_IRQ_MASK: next_irq_mask = I_PWDATA[asw_pkg::IRQ_W-1:0];
            asw_pkg::REG_RETRY_CFG: next_retry_cfg = I_PWDATA[CW-1:0];
            default: next_irq_stat = irq_stat;
         endcase
      end
      // event set wins over clear
      next_irq_stat = next_irq_stat | events;
      next_irq = |(next_irq_stat & next_irq_mask);
      next_pready = I_PSEL && !I_PENABLE;
      next_pslverr = 1'b0;
      next_prdata = '0;
      if (I_PSEL && !I_PENABLE) begin
         unique case (I_PADDR)
            asw_pkg::REG_STATUS: begin
               next_prdata[asw_pkg::ST_PULSE_BIT] = O_PULSE_SEEN;
               next_prdata[asw_pkg::ST_ARMED_BIT] = O_ARMED;
               next_prdata[asw_pkg::ST_LOAD_BIT] = O_LOAD_ACTIVE;
               next_prdata[asw_pkg::ST_RETRY_BIT] = O_RETRY_LIMIT;
               next_prdata[asw_pkg::ST_PERR_BIT] = O_PROG_ERROR;
               next_prdata[asw_pkg::ST_PWR_BIT] = O_POWER_INT;
               next_prdata[asw_pkg::ST_CNT_LSB +: CW] = retry_cnt;
            end
            asw_pkg::REG_IRQ_STAT: next_prdata[asw_pkg::IRQ_W-1:0] = irq_stat;
            asw_pkg::REG_IRQ_MASK: next_prdata[asw_pkg::IRQ_W-1:0] = irq_mask;
            asw_pkg::REG_RETRY_CFG: next_prdata[CW-1:0] = retry_cfg;
            default: next_pslverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge I_MCLK or negedge I_NRST) begin
      if (!I_NRST) begin
         irq_stat <= '0;
         irq_mask <= asw_pkg::IRQ_MASK_RST;
         retry_cfg <= RETRY_RST;
         O_IRQ <= 1'b0;
         O_PREADY <= 1'b0;
         O_PSLVERR <= 1'b0;
         O_PRDATA <= '0;
      end else begin
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         retry_cfg <= next_retry_cfg;
         O_IRQ <= next_irq;
         O_PREADY <= next_pready;
         O_PSLVERR <= next_pslverr;
         O_PRDATA <= next_prdata;
      end
   end

   AST_OFF_IDLE: assert property (!sw_en |=> state == asw_pkg::ST_OFF && !O_ARMED)
      else $error("supervisor active while switched off");
   AST_EN_START: assert property (en_rise |=> state == asw_pkg::ST_WATCH && !hb_exp)
      else $error("enable did not start supervision");
   AST_HB_ERR: assert property (hb_err_evt |=> O_PROG_ERROR && O_LOAD_ACTIVE)
      else $error("heartbeat timeout not flagged");
   AST_PULSE: assert property (sw_en && beat |=> O_PULSE_SEEN)
      else $error("pulse not indicated");
   AST_ARMED: assert property (O_ARMED |-> $past(sw_en && I_CASSETTE_IN && I_LOAD_POINT))
      else $error("armed without its conditions");
   AST_LOAD_ACT: assert property (O_LOAD_ACTIVE |-> state == asw_pkg::ST_LOAD)
      else $error("load active outside a load");
   AST_EXH: assert property (exh_evt |=> O_RETRY_LIMIT && state == asw_pkg::ST_EXHAUST)
      else $error("retry exhaustion not flagged");
   AST_PWR: assert property (I_POWER_FAIL |=> O_POWER_INT)
      else $error("power interruption not latched");
   AST_LATCH: assert property (O_PROG_ERROR && !en_rise |=> O_PROG_ERROR)
      else $error("history flag dropped early");
   AST_INHIBIT: assert property (inhibit && sw_en |=> !O_REWIND)
      else $error("manual rewind passed during reload");
   AST_RETRY_CAP: assert property (state == asw_pkg::ST_LOAD |-> retry_cnt < retry_cfg || retry_cfg == '0)
      else $error("retry count beyond limit");
   AST_SUP_FAIL: assert property (attempt_fail && sw_en |=> state inside {asw_pkg::ST_LOAD, asw_pkg::ST_EXHAUST})
      else $error("expired attempt not failed");
endmodule // asw_top

// [rtl/asw_pkg.sv]
package asw_pkg;

   // clock and timing
   localparam int CLK_HZ = 10_000_000;
   localparam int TICK_HZ = 1000;
   localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
   localparam int HB_TIMEOUT_S = 3;
   localparam int SUP_TIMEOUT_MIN = 5;
   localparam int SEC_PER_MIN = 60;
   localparam int HB_TICKS = HB_TIMEOUT_S * TICK_HZ;
   localparam int SUP_TICKS = SUP_TIMEOUT_MIN * SEC_PER_MIN * TICK_HZ;
   localparam int RETRY_DEF = 3;

   // apb register map
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CNT_W = 8;
   localparam logic [7:0] REG_STATUS = 8'h00;
   localparam logic [7:0] REG_IRQ_STAT = 8'h04;
   localparam logic [7:0] REG_IRQ_MASK = 8'h08;
   localparam logic [7:0] REG_RETRY_CFG = 8'h0c;

   // status register fields
   localparam int ST_PULSE_BIT = 0;
   localparam int ST_ARMED_BIT = 1;
   localparam int ST_LOAD_BIT = 2;
   localparam int ST_RETRY_BIT = 3;
   localparam int ST_PERR_BIT = 4;
   localparam int ST_PWR_BIT = 5;
   localparam int ST_CNT_LSB = 8;

   // interrupt event bits
   localparam int IRQ_W = 4;
   localparam int EV_HB_BIT = 0;
   localparam int EV_EXH_BIT = 1;
   localparam int EV_PWR_BIT = 2;
   localparam int EV_LOAD_BIT = 3;
   localparam logic [3:0] IRQ_MASK_RST = 4'h0;

   typedef enum logic [2:0] {
      ST_OFF,
      ST_WATCH,
      ST_LOAD,
      ST_VERIFY,
      ST_EXHAUST
   } asw_state_t;

endpackage

// [rtl/asw_timer.sv]
`timescale 1ns/100ps
module asw_timer #(
   parameter int LIMIT = 3000
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_tick,
   input wire logic i_restart,
   output logic o_expired
);
   localparam int W = $clog2(LIMIT + 1);
   localparam logic [W-1:0] LIM = W'(LIMIT);

   logic [W-1:0] cnt;
   logic [W-1:0] next_cnt;
   logic next_expired;

   // counts ticks since restart, holds expired until restarted
   always_comb begin
      next_cnt = cnt;
      next_expired = o_expired;
      if (i_restart) begin
         next_cnt = '0;
         next_expired = 1'b0;
      end else if (i_tick && !o_expired) begin
         next_cnt = cnt + W'(1);
         next_expired = (next_cnt >= LIM);
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cnt <= '0;
         o_expired <= 1'b0;
      end else begin
         cnt <= next_cnt;
         o_expired <= next_expired;
      end
   end
endmodule // asw_timer

// [verification/asw_partner.sv]
`timescale 1ns/100ps
module asw_partner (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_beat_en,
   input wire logic i_lid_open,
   input wire logic i_start_load,
   input wire logic [7:0] i_delay,
   output logic o_reset_pulse,
   output logic o_load_point,
   output logic o_drive_ready,
   output logic o_load_done
);
   logic [2:0] beat_cnt;
   logic [7:0] busy_cnt;
   logic busy;
   assign o_drive_ready = ~i_lid_open;
   // tape leaves load point while reading
   assign o_load_point = o_drive_ready & ~busy;
   always_ff @(posedge i_mclk or negedge i_nrst) begin
      if (!i_nrst) begin
         beat_cnt <= 3'h0;
         busy_cnt <= 8'h00;
         busy <= 1'b0;
         o_reset_pulse <= 1'b0;
         o_load_done <= 1'b0;
      end else begin
         beat_cnt <= beat_cnt + 3'h1;
         o_reset_pulse <= i_beat_en & (beat_cnt == 3'h0);
         o_load_done <= 1'b0;
         if (i_lid_open) begin
            busy <= 1'b0;
         end else if (busy) begin
            busy_cnt <= busy_cnt - 8'h01;
            busy <= (busy_cnt != 8'h00);
            o_load_done <= (busy_cnt == 8'h00);
         end else if (i_start_load) begin
            busy <= 1'b1;
            busy_cnt <= i_delay;
         end
      end
   end
endmodule // asw_partner

// [verification/test_autostart_reload_watchdog.sv]
`timescale 1ns/100ps
module test_autostart_reload_watchdog;
   localparam int TC = 4;
   localparam int HB = 5;
   localparam int SUP = 40;
   localparam int RL = 3;
   logic I_MCLK = 1'b0, I_NRST = 1'b0, I_HOST_MCLR = 1'b0, I_PANEL_MCLR = 1'b0;
   logic I_ENABLE_SW = 1'b0, I_CASSETTE_IN = 1'b1, I_POWER_FAIL = 1'b0;
   logic I_MAN_REWIND = 1'b0, I_MANUAL_LOAD_REQUEST = 1'b0;
   logic I_PSEL = 1'b0, I_PENABLE = 1'b0, I_PWRITE = 1'b0;
   logic [asw_pkg::ADDR_W-1:0] I_PADDR = 8'h00;
   logic [31:0] I_PWDATA = 32'h0, O_PRDATA, rd;
   logic beat_en = 1'b0, lid_open = 1'b0, er;
   logic [7:0] load_dly = 8'h14;
   logic I_RESET_PULSE, I_LOAD_POINT, I_DRIVE_READY, I_LOAD_DONE, O_PREADY, O_PSLVERR;
   logic O_PULSE_SEEN, O_ARMED, O_LOAD_ACTIVE, O_RETRY_LIMIT, O_PROG_ERROR, O_POWER_INT;
   logic O_REWIND, O_START_LOAD, O_IRQ;
   int err_count = 0, tests_run = 0;
   asw_top #(.TICK_CYCLES(TC), .HB_TICKS(HB), .SUP_TICKS(SUP), .RETRY_LIMIT(RL)) dut (
      .I_MCLK(I_MCLK), .I_NRST(I_NRST), .I_HOST_MCLR(I_HOST_MCLR),
      .I_PANEL_MCLR(I_PANEL_MCLR), .I_ENABLE_SW(I_ENABLE_SW), .I_RESET_PULSE(I_RESET_PULSE),
      .I_CASSETTE_IN(I_CASSETTE_IN), .I_LOAD_POINT(I_LOAD_POINT),
      .I_DRIVE_READY(I_DRIVE_READY), .I_LOAD_DONE(I_LOAD_DONE), .I_POWER_FAIL(I_POWER_FAIL),
      .I_MAN_REWIND(I_MAN_REWIND), .I_MANUAL_LOAD_REQUEST(I_MANUAL_LOAD_REQUEST),
      .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
      .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
      .O_PULSE_SEEN(O_PULSE_SEEN), .O_ARMED(O_ARMED), .O_LOAD_ACTIVE(O_LOAD_ACTIVE),
      .O_RETRY_LIMIT(O_RETRY_LIMIT), .O_PROG_ERROR(O_PROG_ERROR), .O_POWER_INT(O_POWER_INT),
      .O_REWIND(O_REWIND), .O_START_LOAD(O_START_LOAD), .O_IRQ(O_IRQ)
   );
   asw_partner far (
      .i_mclk(I_MCLK), .i_nrst(I_NRST), .i_beat_en(beat_en), .i_lid_open(lid_open),
      .i_start_load(O_START_LOAD), .i_delay(load_dly), .o_reset_pulse(I_RESET_PULSE),
      .o_load_point(I_LOAD_POINT), .o_drive_ready(I_DRIVE_READY), .o_load_done(I_LOAD_DONE)
   );
   always #50 I_MCLK = ~I_MCLK;
   task automatic cyc(input int n);
      repeat (n) @(posedge I_MCLK);
   endtask
   task automatic chw(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chb(input string nm, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge I_MCLK);
      I_PSEL <= 1'b1;
      I_PENABLE <= 1'b0;
      I_PWRITE <= w;
      I_PADDR <= a;
      I_PWDATA <= d;
      @(posedge I_MCLK);
      I_PENABLE <= 1'b1;
      do begin
         @(posedge I_MCLK);
      end while (O_PREADY !== 1'b1);
      rd = O_PRDATA;
      er = O_PSLVERR;
      I_PSEL <= 1'b0;
      I_PENABLE <= 1'b0;
   endtask
   task automatic wait_lv(ref logic s, input logic v, input int lim, output int n);
      n = 0;
      while (s !== v && n < lim) begin
         @(posedge I_MCLK);
         n++;
      end
      chb("wait in bound", 1'b1, n < lim);
   endtask
   task automatic t_reset();
      chb("flags after reset", 1'b0, O_PROG_ERROR | O_RETRY_LIMIT | O_POWER_INT | O_IRQ);
      apb(1'b0, asw_pkg::REG_STATUS, 32'h0);
      chw("status", 32'h0, rd);
      apb(1'b0, asw_pkg::REG_RETRY_CFG, 32'h0);
      chw("retry cfg", 32'(RL), rd);
      apb(1'b0, asw_pkg::REG_IRQ_MASK, 32'h0);
      chw("mask", 32'h0, rd);
      apb(1'b1, 8'h10, 32'hffffffff);
      chb("unmapped write err", 1'b1, er);
      apb(1'b0, 8'h10, 32'h0);
      chw("unmapped read", 32'h0, rd);
      @(posedge I_MCLK);
      I_MAN_REWIND <= 1'b1;
      I_MANUAL_LOAD_REQUEST <= 1'b1;
      cyc(2);
      @(negedge I_MCLK);
      chb("rewind passed", 1'b1, O_REWIND);
      chb("load passed", 1'b1, O_START_LOAD);
      @(posedge I_MCLK);
      I_MAN_REWIND <= 1'b0;
      I_MANUAL_LOAD_REQUEST <= 1'b0;
   endtask
   task automatic t_disabled();
      cyc(HB * TC * 3);
      @(negedge I_MCLK);
      chb("idle prog error", 1'b0, O_PROG_ERROR);
      chb("idle load", 1'b0, O_LOAD_ACTIVE);
   endtask
   task automatic t_watch();
      @(posedge I_MCLK);
      beat_en <= 1'b1;
      cyc(4);
      I_ENABLE_SW <= 1'b1;
      cyc(HB * TC * 3);
      @(negedge I_MCLK);
      chb("pulse seen", 1'b1, O_PULSE_SEEN);
      chb("armed", 1'b1, O_ARMED);
      chb("no timeout", 1'b0, O_PROG_ERROR);
      @(posedge I_MCLK);
      I_CASSETTE_IN <= 1'b0;
      cyc(3);
      @(negedge I_MCLK);
      chb("armed no cassette", 1'b0, O_ARMED);
      @(posedge I_MCLK);
      I_CASSETTE_IN <= 1'b1;
   endtask
   task automatic t_reload();
      int n;
      @(posedge I_MCLK);
      beat_en <= 1'b0;
      wait_lv(O_PROG_ERROR, 1'b1, 100, n);
      chb("gap bound", 1'b1, n >= HB * TC - 10 && n <= HB * TC + TC + 3);
      @(negedge I_MCLK);
      chb("load active", 1'b1, O_LOAD_ACTIVE);
      wait_lv(O_START_LOAD, 1'b1, 5, n);
      @(posedge I_MCLK);
      I_MAN_REWIND <= 1'b1;
      I_MANUAL_LOAD_REQUEST <= 1'b1;
      lid_open <= 1'b1;
      cyc(3);
      @(negedge I_MCLK);
      chb("rewind blocked", 1'b0, O_REWIND);
      chb("load blocked", 1'b0, O_START_LOAD);
      chb("active lid open", 1'b1, O_LOAD_ACTIVE);
      @(posedge I_MCLK);
      I_MAN_REWIND <= 1'b0;
      I_MANUAL_LOAD_REQUEST <= 1'b0;
      lid_open <= 1'b0;
      wait_lv(O_START_LOAD, 1'b1, 10, n);
      beat_en <= 1'b1;
      wait_lv(O_LOAD_ACTIVE, 1'b0, 100, n);
      cyc(24);
      @(negedge I_MCLK);
      chb("pulses back", 1'b1, O_PULSE_SEEN);
      chb("error held", 1'b1, O_PROG_ERROR);
   endtask
   task automatic t_exhaust();
      int n;
      int starts;
      @(posedge I_MCLK);
      beat_en <= 1'b0;
      load_dly <= 8'h04;
      n = 0;
      starts = 0;
      while (O_RETRY_LIMIT !== 1'b1 && n < 2000) begin
         @(posedge I_MCLK);
         n++;
         if (O_START_LOAD === 1'b1) starts++;
      end
      chw("reload count", 32'(RL), 32'(starts));
      chb("span", 1'b1, n >= RL * (SUP - 1) * TC && n <= RL * (SUP + 2) * TC + 80);
      @(negedge I_MCLK);
      chb("load stopped", 1'b0, O_LOAD_ACTIVE);
      apb(1'b0, asw_pkg::REG_IRQ_STAT, 32'h0);
      chb("exhaust event", 1'b1, rd[asw_pkg::EV_EXH_BIT]);
      @(posedge I_MCLK);
      I_HOST_MCLR <= 1'b1;
      @(posedge I_MCLK);
      I_HOST_MCLR <= 1'b0;
      @(negedge I_MCLK);
      chb("host clear", 1'b0, O_RETRY_LIMIT | O_PROG_ERROR);
      wait_lv(O_PROG_ERROR, 1'b1, 100, n);
      I_PANEL_MCLR <= 1'b1;
      beat_en <= 1'b1;
      @(posedge I_MCLK);
      I_PANEL_MCLR <= 1'b0;
      @(negedge I_MCLK);
      chb("panel clear", 1'b0, O_PROG_ERROR);
   endtask
   task automatic t_power();
      @(posedge I_MCLK);
      I_POWER_FAIL <= 1'b1;
      cyc(2);
      I_POWER_FAIL <= 1'b0;
      apb(1'b1, asw_pkg::REG_IRQ_MASK, 32'h4);
      apb(1'b0, asw_pkg::REG_IRQ_MASK, 32'h0);
      chw("mask readback", 32'h4, rd);
      @(negedge I_MCLK);
      chb("power flag", 1'b1, O_POWER_INT);
      chb("irq raised", 1'b1, O_IRQ);
      apb(1'b1, asw_pkg::REG_IRQ_STAT, 32'h4);
      cyc(2);
      @(negedge I_MCLK);
      chb("irq cleared", 1'b0, O_IRQ);
      @(posedge I_MCLK);
      I_ENABLE_SW <= 1'b0;
      cyc(3);
      @(negedge I_MCLK);
      chb("power held off", 1'b1, O_POWER_INT);
      @(posedge I_MCLK);
      I_ENABLE_SW <= 1'b1;
      cyc(3);
      @(negedge I_MCLK);
      chb("power cleared", 1'b0, O_POWER_INT);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      cyc(8);
      I_NRST <= 1'b1;
      @(negedge I_MCLK);
      t_reset();
      t_disabled();
      t_watch();
      t_reload();
      t_exhaust();
      t_power();
      end_of_test();
   end
   initial begin
      #1_000_000;
      err_count++;
      end_of_test();
   end
endmodule // test_autostart_reload_watchdog
